// *** logic/supply_monitor_regs.vh ***
// register map, field positions and reset values of the supply monitor control
`ifndef SUPPLY_MONITOR_REGS_VH
`define SUPPLY_MONITOR_REGS_VH

// register offsets (byte addresses on the plain register port)
`define SM_ADDR_STATUS 8'h00
`define SM_ADDR_CONFIG 8'h01
`define SM_ADDR_EVENT 8'h02
`define SM_ADDR_MASK 8'h03

// status register fields
`define SM_STATUS_FLAG_BIT 0

// configuration register fields
`define SM_CFG_STOP_EN_BIT 0
`define SM_CFG_PWR_DIS_BIT 1
`define SM_CFG_TRIP_BIT 2
`define SM_CFG_RST_DIS_BIT 3

// configuration reset values: monitor on, resets on, low range, off in stop
`define SM_CFG_STOP_EN_RST 1'b0
`define SM_CFG_PWR_DIS_RST 1'b0
`define SM_CFG_TRIP_RST 1'b0
`define SM_CFG_RST_DIS_RST 1'b0

// event register fields
`define SM_EVT_WIDTH 3
`define SM_EVT_LOW_BIT 0
`define SM_EVT_RECOVER_BIT 1
`define SM_EVT_RESET_BIT 2
`define SM_EVT_RST 3'h0
`define SM_MASK_RST 3'h0

// synchroniser depth in flip-flops
`define SM_SYNC_STAGES 2

// edges a comparator result needs after an enable or range change:
// output register plus both synchroniser stages
`define SM_SETTLE_STAGES 3

`endif

// *** logic/level_sync.v ***
// two-flip-flop synchroniser for a group of level signals
`timescale 1ns/1ps
`default_nettype none

`include "supply_monitor_regs.vh"

module level_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    genvar g;

    // one independent two-stage chain per bit; the first stage feeds only the second
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : chain
            reg meta; // first stage, may go metastable
            reg stable; // second stage, safe to use
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= async_i[g];
                    stable <= meta;
                end
            end
            assign sync_o[g] = stable;
        end
    endgenerate

endmodule

`default_nettype wire

// *** logic/event_irq.v ***
// sticky event bits with write-one-to-clear, a mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none

`include "supply_monitor_regs.vh"

module event_irq (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // hardware event pulses
    input wire [`SM_EVT_WIDTH-1:0] set_i,
    // software access
    input wire clear_wr_i,
    input wire mask_wr_i,
    input wire [`SM_EVT_WIDTH-1:0] wdata_i,
    // state and interrupt
    output wire [`SM_EVT_WIDTH-1:0] status_o,
    output wire [`SM_EVT_WIDTH-1:0] mask_o,
    output reg irq_o
);

    reg [`SM_EVT_WIDTH-1:0] pending; // sticky event bits
    reg [`SM_EVT_WIDTH-1:0] mask; // one enables the bit onto irq_o
    reg [`SM_EVT_WIDTH-1:0] next_pending; // pending after this cycle

    genvar g;

    // per bit: a new event beats a clear in the same cycle, so nothing is lost
    generate
        for (g = 0; g < `SM_EVT_WIDTH; g = g + 1) begin : bitwise
            always @* begin
                next_pending[g] = pending[g];
                if (clear_wr_i && wdata_i[g]) begin
                    next_pending[g] = 1'b0;
                end
                if (set_i[g]) begin
                    next_pending[g] = 1'b1;
                end
            end
        end
    endgenerate

    // state registers; irq follows next state so it lines up with the bits
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending <= `SM_EVT_RST;
            mask <= `SM_MASK_RST;
            irq_o <= 1'b0;
        end else begin
            pending <= next_pending;
            if (mask_wr_i) begin
                mask <= wdata_i;
            end
            irq_o <= |(next_pending & (mask_wr_i ? wdata_i : mask));
        end
    end

    assign status_o = pending;
    assign mask_o = mask;

endmodule

`default_nettype wire

// *** logic/supply_undervoltage_monitor_ctrl.v ***
// control logic of the supply undervoltage monitor: status flag, reset request, config
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

`include "supply_monitor_regs.vh"

module supply_undervoltage_monitor_ctrl (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // analog comparator side
    input wire below_falling_i,
    input wire above_rising_i,
    output reg comparator_enable_o,
    output reg trip_range_select_o,
    // system side
    input wire stop_mode_i,
    output reg undervoltage_reset_o,
    output reg low_supply_flag_o,
    // event interrupt
    output reg irq_o
);

    // configuration bits
    reg monitor_in_stop_enable; // keep running in stop mode
    reg monitor_power_disable; // switch the monitor off entirely
    reg trip_range_select; // high supply range when set
    reg monitor_reset_disable; // never raise a reset when set
    reg trip_written; // trip range has taken its one write

    // monitor state
    reg low_supply_flag; // hysteretic low supply status
    reg reset_request; // undervoltage reset held towards the system
    reg range_check; // high range check waiting for the comparator to settle
    reg [`SM_SETTLE_STAGES-1:0] comp_ready; // edges the comparator has been on in one range

    // synchronised comparator levels
    wire [1:0] comp_sync;
    wire below_falling; // supply under the falling threshold
    wire above_rising; // supply over the rising threshold

    // decoded accesses
    wire wr_config;
    wire wr_event;
    wire wr_mask;
    wire monitor_active;
    wire reset_enable;
    wire comp_valid; // comparator powered and settled in its current range
    wire trip_load; // first config write that switches to the high range
    wire next_flag;
    wire next_reset;

    // event interface
    wire [`SM_EVT_WIDTH-1:0] events;
    wire [`SM_EVT_WIDTH-1:0] event_status;
    wire [`SM_EVT_WIDTH-1:0] event_mask;
    wire event_irq_level;
    reg [7:0] next_rdata;

    // comparator outputs come from the analog domain, so retime them first
    level_sync #(
        .WIDTH(2)
    ) u_comp_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({above_rising_i, below_falling_i}),
        .sync_o(comp_sync)
    );

    assign below_falling = comp_sync[0];
    assign above_rising = comp_sync[1];

    // address decode for writes; the status register has no write path
    assign wr_config = wr_i && (addr_i == `SM_ADDR_CONFIG);
    assign wr_event = wr_i && (addr_i == `SM_ADDR_EVENT);
    assign wr_mask = wr_i && (addr_i == `SM_ADDR_MASK);

    // monitor runs unless powered off; in stop mode only with stop enable.
    // wait mode needs no term: the monitor simply keeps running there
    assign monitor_active = !monitor_power_disable &&
        (!stop_mode_i || monitor_in_stop_enable);

    // reset generation needs an active monitor and no reset disable
    assign reset_enable = monitor_active && !monitor_reset_disable;

    // an unpowered or just re-ranged comparator gives no trustworthy level; its
    // outputs count only once enable and range have stood through the output
    // register and both synchroniser stages, else a power-up would fake a drop
    assign trip_load = wr_config && !trip_written && wdata_i[`SM_CFG_TRIP_BIT];
    assign comp_valid = &comp_ready;

    // flag: set below falling, cleared above rising, held in between
    assign next_flag = !(monitor_active && comp_valid) ? low_supply_flag :
        below_falling ? 1'b1 :
        above_rising ? 1'b0 :
        low_supply_flag;

    // reset: raised on a drop or a failed high-range check, held until recovery
    assign next_reset = (reset_request && !(comp_valid && above_rising)) ||
        (reset_enable && comp_valid && below_falling) ||
        (reset_enable && comp_valid && range_check && !above_rising);

    // configuration register; trip range takes one write after reset
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            monitor_in_stop_enable <= `SM_CFG_STOP_EN_RST;
            monitor_power_disable <= `SM_CFG_PWR_DIS_RST;
            trip_range_select <= `SM_CFG_TRIP_RST;
            monitor_reset_disable <= `SM_CFG_RST_DIS_RST;
            trip_written <= 1'b0;
            range_check <= 1'b0;
        end else begin
            // the range check runs once, on the first settled cycle after the switch
            if (comp_valid) begin
                range_check <= 1'b0;
            end
            if (wr_config) begin
                monitor_in_stop_enable <= wdata_i[`SM_CFG_STOP_EN_BIT];
                monitor_power_disable <= wdata_i[`SM_CFG_PWR_DIS_BIT];
                monitor_reset_disable <= wdata_i[`SM_CFG_RST_DIS_BIT];
                if (!trip_written) begin
                    // first write fixes the range; later ones leave it alone
                    trip_range_select <= wdata_i[`SM_CFG_TRIP_BIT];
                    trip_written <= 1'b1;
                    range_check <= wdata_i[`SM_CFG_TRIP_BIT];
                end
            end
        end
    end

    // settle history; a range switch restarts it just like a power-up
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_ready <= {`SM_SETTLE_STAGES{1'b0}};
        end else begin
            comp_ready <= {comp_ready[`SM_SETTLE_STAGES-2:0], monitor_active && !trip_load};
        end
    end

    // monitor state: status flag and held reset request
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_supply_flag <= 1'b0;
            reset_request <= 1'b0;
        end else begin
            low_supply_flag <= next_flag;
            reset_request <= next_reset;
        end
    end

    // events: flag rise, flag fall, reset raised; one-cycle pulses
    assign events[`SM_EVT_LOW_BIT] = next_flag && !low_supply_flag;
    assign events[`SM_EVT_RECOVER_BIT] = !next_flag && low_supply_flag;
    assign events[`SM_EVT_RESET_BIT] = next_reset && !reset_request;

    // sticky event bits, mask and interrupt; mask resets to zero so the
    // monitor proper stays silent unless software opts in
    event_irq u_event_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(events),
        .clear_wr_i(wr_event),
        .mask_wr_i(wr_mask),
        .wdata_i(wdata_i[`SM_EVT_WIDTH-1:0]),
        .status_o(event_status),
        .mask_o(event_mask),
        .irq_o(event_irq_level)
    );

    // read mux; unmapped addresses and reserved bits read zero
    always @* begin
        next_rdata = 8'h00;
        case (addr_i)
            `SM_ADDR_STATUS: begin
                next_rdata[`SM_STATUS_FLAG_BIT] = low_supply_flag;
            end
            `SM_ADDR_CONFIG: begin
                next_rdata[`SM_CFG_STOP_EN_BIT] = monitor_in_stop_enable;
                next_rdata[`SM_CFG_PWR_DIS_BIT] = monitor_power_disable;
                next_rdata[`SM_CFG_TRIP_BIT] = trip_range_select;
                next_rdata[`SM_CFG_RST_DIS_BIT] = monitor_reset_disable;
            end
            `SM_ADDR_EVENT: begin
                next_rdata[`SM_EVT_WIDTH-1:0] = event_status;
            end
            `SM_ADDR_MASK: begin
                next_rdata[`SM_EVT_WIDTH-1:0] = event_mask;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // registered outputs; read data stands only in the cycle after the strobe
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            comparator_enable_o <= 1'b1;
            trip_range_select_o <= 1'b0;
            undervoltage_reset_o <= 1'b0;
            low_supply_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
            comparator_enable_o <= monitor_active;
            trip_range_select_o <= trip_range_select;
            undervoltage_reset_o <= reset_request;
            low_supply_flag_o <= low_supply_flag;
            // block-level event line only; no supply interrupt request exists
            irq_o <= event_irq_level;
        end
    end

endmodule

`default_nettype wire

// *** bench/supply_monitor_properties.sv ***
// port assertions of the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // comparator side
    input wire logic below_falling_i,
    input wire logic above_rising_i,
    input wire logic comparator_enable_o,
    input wire logic trip_range_select_o,
    // system side
    input wire logic undervoltage_reset_o,
    input wire logic low_supply_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // five samples cover the synchroniser, the flag and the output register
    sequence s_low;
        (below_falling_i && comparator_enable_o) [*5];
    endsequence
    sequence s_high;
        (above_rising_i && comparator_enable_o) [*5];
    endsequence
    a_flag_sets: assert property (s_low |=> low_supply_flag_o)
        else $error("flag missed low supply");
    a_flag_clears: assert property (s_high |=> !low_supply_flag_o)
        else $error("flag missed recovery");
    a_flag_holds: assert property (
        (!below_falling_i && !above_rising_i) [*5] |=> $stable(low_supply_flag_o))
        else $error("flag moved between thresholds");
    a_reset_release: assert property (s_high |=> !undervoltage_reset_o)
        else $error("reset not released");
    a_reset_held: assert property (
        (!above_rising_i) [*4] ##0 undervoltage_reset_o |=> undervoltage_reset_o)
        else $error("reset dropped early");
    // a reset only follows a low flag or the high range check
    a_reset_cause: assert property ($rose(undervoltage_reset_o)
        |-> low_supply_flag_o || trip_range_select_o) else $error("reset without cause");
    a_trip_sticky: assert property (trip_range_select_o |=> trip_range_select_o)
        else $error("range select cleared");
    a_off_frozen: assert property (
        (!comparator_enable_o) [*5] |=> $stable(low_supply_flag_o))
        else $error("flag moved while off");
endmodule
`default_nettype wire

// *** bench/supply_comparator_model.sv ***
// behavioural model of the analog supply comparator with hysteresis
`timescale 1ns/1ps
`default_nettype none
module supply_comparator_model #(
    // trip points in millivolts, plain arbitrary defaults
    parameter int FALL_LO = 2600,
    parameter int FALL_HI = 4200,
    parameter int HYS = 100
) (
    // clock only scrambles the outputs while unpowered
    input wire logic clk_i,
    // supply and analog controls
    input wire logic [15:0] supply_mv_i,
    input wire logic enable_i,
    input wire logic high_range_i,
    // comparator results
    output logic below_o,
    output logic above_o
);
    logic scramble = 1'b0; // changes every cycle
    int fall;
    assign fall = high_range_i ? FALL_HI : FALL_LO;
    always @(posedge clk_i) begin
        scramble <= ~scramble;
    end
    // an unpowered comparator gives no trustworthy level, so it toggles
    always @* begin
        if (enable_i) begin
            below_o = int'(supply_mv_i) < fall;
            above_o = int'(supply_mv_i) > fall + HYS;
        end else begin
            below_o = scramble;
            above_o = ~scramble;
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_regs.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic [15:0] supply_mv = 16'h0BB8; // healthy supply at start
    wire [7:0] rdata_o;
    wire below_falling_i, above_rising_i, comparator_enable_o, trip_range_select_o;
    wire undervoltage_reset_o, low_supply_flag_o, irq_o;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] expect_q[$]; // read notes, oldest first
    logic [7:0] exp_rd;
    logic rd_prev = 1'b0;
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    supply_undervoltage_monitor_ctrl u_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .below_falling_i, .above_rising_i, .comparator_enable_o,
        .trip_range_select_o, .stop_mode_i, .undervoltage_reset_o, .low_supply_flag_o,
        .irq_o);
    supply_comparator_model u_comp (.clk_i, .supply_mv_i(supply_mv),
        .enable_i(comparator_enable_o), .high_range_i(trip_range_select_o),
        .below_o(below_falling_i), .above_o(above_rising_i));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // four edges of latency plus margin, then look at settled outputs
    task automatic settle();
        cyc(6);
        @(negedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        expect_q.push_back(e);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic supply(input logic [15:0] v);
        @(posedge clk_i);
        supply_mv <= v;
        settle();
    endtask
    task automatic outs(input logic r, input logic f);
        `CHK(undervoltage_reset_o, r)
        `CHK(low_supply_flag_o, f)
    endtask
    function automatic logic [15:0] mv(input int base, input int span);
        return 16'(base + $urandom_range(0, span));
    endfunction
    task automatic tally_and_finish();
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(negedge clk_i) begin
        if (rd_prev) begin
            exp_rd = expect_q.pop_front();
            `CHK(rdata_o, exp_rd)
        end
        rd_prev = rd_i;
    end
    // a hang is cut short well beyond the 150 or so cycles needed
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(99));
        cyc(2);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK(comparator_enable_o, 1'b1)
        outs(1'b0, 1'b0);
        rd(`SM_ADDR_CONFIG, 8'h00);
        supply(mv(2000, 500));
        outs(1'b1, 1'b1);
        wr(`SM_ADDR_STATUS, 8'hFE);
        rd(`SM_ADDR_STATUS, 8'h01);
        supply(mv(2610, 80));
        outs(1'b1, 1'b1);
        supply(mv(2710, 900));
        outs(1'b0, 1'b0);
        rd(`SM_ADDR_EVENT, 8'h07);
        `CHK(irq_o, 1'b0)
        wr(`SM_ADDR_MASK, 8'h04);
        settle();
        `CHK(irq_o, 1'b1)
        wr(`SM_ADDR_EVENT, 8'h07);
        rd(`SM_ADDR_EVENT, 8'h00);
        `CHK(irq_o, 1'b0)
        wr(`SM_ADDR_MASK, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        // polled mode, then power down, then stop mode
        wr(`SM_ADDR_CONFIG, 8'h08);
        supply(mv(2000, 500));
        outs(1'b0, 1'b1);
        wr(`SM_ADDR_CONFIG, 8'h0C);
        rd(`SM_ADDR_CONFIG, 8'h08);
        supply(mv(2710, 900));
        wr(`SM_ADDR_CONFIG, 8'h0A);
        supply(mv(2000, 500));
        `CHK(comparator_enable_o, 1'b0)
        outs(1'b0, 1'b0);
        supply(mv(2710, 900));
        // powering back up must not act on the comparator before it is valid
        wr(`SM_ADDR_EVENT, 8'h07);
        wr(`SM_ADDR_CONFIG, 8'h00);
        settle();
        rd(`SM_ADDR_EVENT, 8'h00);
        stop_mode_i <= 1'b1;
        supply(mv(2000, 500));
        outs(1'b0, 1'b0);
        wr(`SM_ADDR_CONFIG, 8'h01);
        settle();
        outs(1'b1, 1'b1);
        supply(mv(2710, 900));
        outs(1'b0, 1'b0);
        @(posedge clk_i);
        stop_mode_i <= 1'b0;
        // second reset, then the high range with a supply between its trip points
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        supply(mv(4210, 80));
        outs(1'b0, 1'b0);
        wr(`SM_ADDR_CONFIG, 8'h04);
        settle();
        `CHK(trip_range_select_o, 1'b1)
        outs(1'b1, 1'b0);
        supply(mv(4310, 500));
        outs(1'b0, 1'b0);
        wr(`SM_ADDR_CONFIG, 8'h00);
        rd(`SM_ADDR_CONFIG, 8'h04);
        cyc(2);
        tally_and_finish();
    end
endmodule
bind supply_undervoltage_monitor_ctrl supply_monitor_checker u_chk (.clk_i, .rst_i,
    .below_falling_i, .above_rising_i, .comparator_enable_o, .trip_range_select_o,
    .undervoltage_reset_o, .low_supply_flag_o);
`default_nettype wire
